// ===== core/supervisor_pkg.sv
// Purpose: shared constants of the regulator supervisor
// Assumes: 25 MHz core clock, converter codes in millivolts
// Notes: register map uses word offsets on the local port
package supervisor_pkg;
  // ****************************************
  // timing
  // ****************************************
  localparam int CLK_PERIOD_NS = 40;
  localparam int OC_TIME_NS = 50000;
  localparam int OC_CYCLES = (OC_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int OC_CNT_W = 11;

  // ****************************************
  // widths and converter channels
  // ****************************************
  localparam int MV_W = 11;
  localparam int DATA_W = 16;
  localparam int ADDR_W = 8;
  localparam logic [1:0] CH_BOOT = 2'h0;
  localparam logic [1:0] CH_MAX_CURRENT_PROGRAM_PIN = 2'h1;
  localparam logic [1:0] CH_TEMP = 2'h2;
  localparam logic [1:0] CH_OUTPUT_CURRENT_REPORT = 2'h3;

  // ****************************************
  // register offsets
  // ****************************************
  localparam logic [7:0] REG_RATE = 8'h01;
  localparam logic [7:0] REG_VID = 8'h02;
  localparam logic [7:0] REG_STATUS = 8'h03;
  localparam logic [7:0] REG_BOOTCFG = 8'h04;
  localparam logic [7:0] REG_ICCMAX = 8'h05;
  localparam logic [7:0] REG_OUTPUT_CURRENT_REPORT = 8'h06;
  localparam logic [7:0] REG_LINK = 8'h07;
  localparam logic [7:0] REG_TEMP = 8'h17;
  localparam logic [7:0] REG_ZEROCFG = 8'h34;
  localparam int ZERO_GOOD_BIT = 0;
  localparam logic [1:0] RATE_RESET = 2'h0;

  // ****************************************
  // boot band decode
  // ****************************************
  localparam int BAND_EDGES = 17;
  localparam int BANDS_PER_LEVEL = 9;
  localparam logic [MV_W-1:0] BAND_EDGE [BAND_EDGES] = '{
    11'h066, 11'h0b4, 11'h102, 11'h158, 11'h1b6, 11'h213, 11'h271, 11'h2d7,
    11'h344, 11'h3b9, 11'h426, 11'h4a4, 11'h520, 11'h5a5, 11'h62a, 11'h6b7,
    11'h743};
  localparam logic [7:0] BOOT_CODE_LO = 8'h64;
  localparam logic [7:0] BOOT_CODE_HI = 8'h6e;

  // ****************************************
  // conversions and thermal levels
  // ****************************************
  localparam logic [15:0] MAX_CURRENT_PROGRAM_PIN_MA_PER_MV = 16'h0020;
  localparam logic [MV_W-1:0] OUTPUT_CURRENT_REPORT_FULL_MV = 11'h7d0;
  localparam logic [MV_W-1:0] TEMP_ALERT_MV = 11'h190;
  localparam logic [MV_W-1:0] TEMP_HOT_MV = 11'h12c;
  localparam logic [7:0] TEMP_BASE_C = 8'h96;
  localparam int TEMP_SHIFT = 3;

  typedef enum logic [2:0] {
    ST_OFF = 3'b000,
    ST_CAL = 3'b001,
    ST_SOFT = 3'b011,
    ST_RUN = 3'b010,
    ST_OV_RAMP = 3'b110,
    ST_OV_HOLD = 3'b111,
    ST_OC = 3'b100
  } state_e;
endpackage : supervisor_pkg

// ===== core/regulator_supervisor.sv
// Purpose: fault, configuration and telemetry supervisor of a buck regulator
// Assumes: comparator levels and link pins are asynchronous, converter is on-clock
// Notes: analog loop, sense gain and bus protocol framing live elsewhere
`timescale 1ns/10ps
`default_nettype none
module regulator_supervisor
  import supervisor_pkg::*;
#(
  parameter int STEP_DIV_FAST = 25,
  parameter int STEP_DIV_MID = 50,
  parameter int STEP_DIV_SLOW = 100
) (
  input wire logic CLOCK_IN,
  input wire logic RST_N_IN,
  input wire logic [ADDR_W-1:0] ADDR_IN,
  input wire logic [DATA_W-1:0] WDATA_IN,
  input wire logic WR_IN,
  input wire logic RD_IN,
  output logic [DATA_W-1:0] RDATA_OUT,
  input wire logic [MV_W-1:0] ADC_CODE_IN,
  input wire logic [1:0] ADC_CHAN_IN,
  input wire logic ADC_VALID_IN,
  input wire logic ENABLE_IN,
  input wire logic VCC_OK_IN,
  input wire logic VIN_OK_IN,
  input wire logic CURRENT_LIMIT_SENSE_IN,
  input wire logic FAST_CURRENT_LIMIT_IN,
  input wire logic UNDERVOLTAGE_COMPARATOR_IN,
  input wire logic OUT_ABOVE_OV_IN,
  input wire logic OUT_ABOVE_FIXED_OV_IN,
  input wire logic PWM_IN,
  input wire logic BUS_CLK_IN,
  input wire logic BUS_DATA_IN,
  output logic BUS_DATA_OUT,
  output logic BUS_DATA_OE_OUT,
  output logic BUS_ALERT_N_OUT,
  output logic BUS_ALERT_OE_OUT,
  output logic [7:0] TARGET_OUT,
  output logic HIGH_SIDE_GATE_OUT,
  output logic LOW_SIDE_GATE_OUT,
  output logic OUTPUT_GOOD_OUT,
  output logic OVER_TEMP_FLAG_N_OUT
);

  // ****************************************
  // functions
  // ****************************************
  function automatic logic [4:0] band_of(input logic [MV_W-1:0] mv);
    logic [4:0] n;
    n = 5'h00;
    for (int i = 0; i < BAND_EDGES; i++) begin
      if (mv >= BAND_EDGE[i]) begin
        n = n + 5'h01;
      end
    end
    return n;
  endfunction : band_of

  function automatic logic [7:0] temp_of(input logic [MV_W-1:0] mv);
    logic [MV_W-1:0] drop;
    drop = mv >> TEMP_SHIFT;
    if (drop >= {3'h0, TEMP_BASE_C}) begin
      return 8'h00;
    end
    return TEMP_BASE_C - drop[7:0];
  endfunction : temp_of

  // ****************************************
  // input synchronisers
  // ****************************************
  localparam int NSYNC = 10;
  logic [NSYNC-1:0] meta_r;
  logic [NSYNC-1:0] sync_r;
  logic bus_clk_d_r;
  always_ff @(posedge CLOCK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      meta_r <= '0;
      sync_r <= '0;
      bus_clk_d_r <= 1'b0;
    end else begin
      meta_r <= {BUS_DATA_IN, BUS_CLK_IN, PWM_IN, OUT_ABOVE_FIXED_OV_IN, OUT_ABOVE_OV_IN,
                 UNDERVOLTAGE_COMPARATOR_IN, FAST_CURRENT_LIMIT_IN,
                 CURRENT_LIMIT_SENSE_IN, VIN_OK_IN & VCC_OK_IN, ENABLE_IN};
      sync_r <= meta_r;
      bus_clk_d_r <= sync_r[8];
    end
  end
  logic enable_s;
  logic supply_ok_s;
  logic cur_lim_s;
  logic fast_lim_s;
  logic uv_s;
  logic ov_s;
  logic ov_fixed_s;
  logic pwm_s;
  logic bus_clk_rise;
  assign enable_s = sync_r[0];
  assign supply_ok_s = sync_r[1];
  assign cur_lim_s = sync_r[2];
  assign fast_lim_s = sync_r[3];
  assign uv_s = sync_r[4];
  assign ov_s = sync_r[5];
  assign ov_fixed_s = sync_r[6];
  assign pwm_s = sync_r[7];
  assign bus_clk_rise = sync_r[8] & ~bus_clk_d_r;

  // ****************************************
  // register port
  // ****************************************
  logic [1:0] rate_r;
  logic [7:0] vid_r;
  logic zero_good_r;
  logic [15:0] link_edges_r;
  state_e state_r;
  logic [7:0] target_r;
  // host selects one of three rates
  always_ff @(posedge CLOCK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      rate_r <= RATE_RESET;
      zero_good_r <= 1'b0;
    end else if (WR_IN && ADDR_IN == REG_RATE) begin
      rate_r <= (WDATA_IN[1:0] == 2'h3) ? 2'h2 : WDATA_IN[1:0];
    end else if (WR_IN && ADDR_IN == REG_ZEROCFG) begin
      zero_good_r <= WDATA_IN[ZERO_GOOD_BIT];
    end
  end

  always_ff @(posedge CLOCK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      link_edges_r <= 16'h0000;
    end else if (bus_clk_rise) begin
      link_edges_r <= link_edges_r + 16'h0001;
    end
  end

  // ****************************************
  // startup configuration capture
  // ****************************************
  logic got_boot_r;
  logic got_max_current_program_pin_r;
  logic [3:0] bus_addr_r;
  logic boot_hi_r;
  logic [15:0] iccmax_r;
  logic cfg_done;
  logic [4:0] band;
  assign cfg_done = got_boot_r & got_max_current_program_pin_r;
  assign band = band_of(ADC_CODE_IN);
  always_ff @(posedge CLOCK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      got_boot_r <= 1'b0;
      bus_addr_r <= 4'h0;
      boot_hi_r <= 1'b0;
    end else if (ADC_VALID_IN && ADC_CHAN_IN == CH_BOOT && !got_boot_r) begin
      got_boot_r <= 1'b1;
      boot_hi_r <= (band >= 5'(BANDS_PER_LEVEL));
      bus_addr_r <= (band >= 5'(BANDS_PER_LEVEL)) ? 4'(band - 5'(BANDS_PER_LEVEL)) : band[3:0];
    end
  end

  always_ff @(posedge CLOCK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      got_max_current_program_pin_r <= 1'b0;
      iccmax_r <= 16'h0000;
    end else if (ADC_VALID_IN && ADC_CHAN_IN == CH_MAX_CURRENT_PROGRAM_PIN && !got_max_current_program_pin_r) begin
      got_max_current_program_pin_r <= 1'b1;
      iccmax_r <= 16'({5'h00, ADC_CODE_IN} * MAX_CURRENT_PROGRAM_PIN_MA_PER_MV);
    end
  end

  // ****************************************
  // telemetry
  // ****************************************
  logic [7:0] temp_r;
  logic [15:0] output_current_report_r;
  logic [26:0] output_current_report_prod;
  assign output_current_report_prod = {16'h0000, ADC_CODE_IN} * {11'h000, iccmax_r};
  always_ff @(posedge CLOCK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      temp_r <= 8'h00;
      output_current_report_r <= 16'h0000;
    end else if (ADC_VALID_IN && state_r == ST_RUN) begin
      if (ADC_CHAN_IN == CH_TEMP) begin
        temp_r <= temp_of(ADC_CODE_IN);
      end
      if (ADC_CHAN_IN == CH_OUTPUT_CURRENT_REPORT) begin
        output_current_report_r <= 16'(output_current_report_prod / {16'h0000, OUTPUT_CURRENT_REPORT_FULL_MV});
      end
    end
  end

  logic alert_r;
  logic hot_r;
  always_ff @(posedge CLOCK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      alert_r <= 1'b0;
      hot_r <= 1'b0;
    end else if (state_r != ST_RUN) begin
      alert_r <= 1'b0;
      hot_r <= 1'b0;
    end else if (ADC_VALID_IN && ADC_CHAN_IN == CH_TEMP) begin
      alert_r <= ADC_CODE_IN < TEMP_ALERT_MV;
      hot_r <= ADC_CODE_IN < TEMP_HOT_MV;
    end
  end

  // ****************************************
  // ramp step divider
  // ****************************************
  logic [15:0] div_r;
  logic [15:0] div_lim;
  logic step;
  always_comb begin
    unique case (state_r == ST_OV_RAMP ? 2'h2 : rate_r)
      2'h0: div_lim = 16'(STEP_DIV_FAST - 1);
      2'h1: div_lim = 16'(STEP_DIV_MID - 1);
      default: div_lim = 16'(STEP_DIV_SLOW - 1);
    endcase
  end
  assign step = (div_r >= div_lim);
  always_ff @(posedge CLOCK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      div_r <= 16'h0000;
    end else begin
      div_r <= step ? 16'h0000 : div_r + 16'h0001;
    end
  end

  // ****************************************
  // overcurrent latch-off timer
  // ****************************************
  logic [OC_CNT_W-1:0] oc_cnt_r;
  logic oc_expire;
  assign oc_expire = cur_lim_s && oc_cnt_r == OC_CNT_W'(OC_CYCLES - 1);
  // timer restarts on each fresh excess
  always_ff @(posedge CLOCK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      oc_cnt_r <= '0;
    end else if (!cur_lim_s || (state_r != ST_RUN && state_r != ST_SOFT)) begin
      oc_cnt_r <= '0;
    end else if (!oc_expire) begin
      oc_cnt_r <= oc_cnt_r + OC_CNT_W'(1);
    end
  end

  // ****************************************
  // sequence state machine
  // ****************************************
  logic [7:0] boot_code;
  logic active;
  assign boot_code = boot_hi_r ? BOOT_CODE_HI : BOOT_CODE_LO;
  assign active = (state_r == ST_SOFT) || (state_r == ST_RUN);
  always_ff @(posedge CLOCK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      state_r <= ST_OFF;
    end else begin
      unique case (state_r)
        ST_OFF: if (enable_s && supply_ok_s) state_r <= ST_CAL;
        ST_CAL: begin
          if (!enable_s || !supply_ok_s) begin
            state_r <= ST_OFF;
          end else if (cfg_done) begin
            state_r <= ST_SOFT;
          end
        end
        ST_SOFT, ST_RUN: begin
          if (!enable_s || !supply_ok_s) begin
            state_r <= ST_OFF;
          end else if (fast_lim_s || oc_expire) begin
            state_r <= ST_OC;
          end else if (state_r == ST_SOFT ? ov_fixed_s : ov_s) begin
            state_r <= ST_OV_RAMP;
          end else if (state_r == ST_SOFT && target_r == boot_code && step) begin
            state_r <= ST_RUN;
          end
        end
        // ramp ends in hold at zero
        ST_OV_RAMP: begin
          if (!enable_s) begin
            state_r <= ST_OFF;
          end else if (target_r == 8'h00) begin
            state_r <= ST_OV_HOLD;
          end
        end
        ST_OV_HOLD, ST_OC: if (!enable_s) state_r <= ST_OFF;
        default: state_r <= ST_OFF;
      endcase
    end
  end

  // ****************************************
  // target code
  // ****************************************
  always_ff @(posedge CLOCK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      target_r <= 8'h00;
    end else if (state_r == ST_OFF || state_r == ST_CAL) begin
      target_r <= 8'h00;
    end else if (step) begin
      if (state_r == ST_OV_RAMP && target_r != 8'h00) begin
        target_r <= target_r - 8'h01;
      end else if (state_r == ST_SOFT && target_r < boot_code) begin
        target_r <= target_r + 8'h01;
      end else if (state_r == ST_RUN && target_r < vid_r) begin
        target_r <= target_r + 8'h01;
      end else if (state_r == ST_RUN && target_r > vid_r) begin
        target_r <= target_r - 8'h01;
      end
    end
  end

  always_ff @(posedge CLOCK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      vid_r <= 8'h00;
    end else if (state_r == ST_CAL) begin
      vid_r <= boot_code;
    end else if (WR_IN && ADDR_IN == REG_VID) begin
      vid_r <= WDATA_IN[7:0];
    end
  end

  // ****************************************
  // gate drives and output good
  // ****************************************
  always_ff @(posedge CLOCK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      HIGH_SIDE_GATE_OUT <= 1'b0;
      LOW_SIDE_GATE_OUT <= 1'b0;
    end else begin
      unique case (state_r)
        ST_SOFT, ST_RUN: begin
          HIGH_SIDE_GATE_OUT <= pwm_s;
          LOW_SIDE_GATE_OUT <= ~pwm_s;
        end
        ST_OV_RAMP: begin
          HIGH_SIDE_GATE_OUT <= 1'b0;
          LOW_SIDE_GATE_OUT <= ov_s;
        end
        ST_OV_HOLD: begin
          HIGH_SIDE_GATE_OUT <= 1'b0;
          LOW_SIDE_GATE_OUT <= 1'b1;
        end
        default: begin
          HIGH_SIDE_GATE_OUT <= 1'b0;
          LOW_SIDE_GATE_OUT <= 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge CLOCK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      OUTPUT_GOOD_OUT <= 1'b0;
    end else if (state_r != ST_RUN) begin
      OUTPUT_GOOD_OUT <= 1'b0;
    end else if (target_r == 8'h00) begin
      OUTPUT_GOOD_OUT <= zero_good_r;
    end else begin
      OUTPUT_GOOD_OUT <= ~uv_s;
    end
  end

  // ****************************************
  // read port and pins
  // ****************************************
  always_ff @(posedge CLOCK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      RDATA_OUT <= '0;
    end else if (RD_IN) begin
      unique case (ADDR_IN)
        REG_RATE: RDATA_OUT <= {14'h0000, rate_r};
        REG_VID: RDATA_OUT <= {8'h00, vid_r};
        REG_STATUS: RDATA_OUT <= {8'h00, hot_r, alert_r, cfg_done, 2'h0, state_r};
        REG_BOOTCFG: RDATA_OUT <= {11'h000, boot_hi_r, bus_addr_r};
        REG_ICCMAX: RDATA_OUT <= iccmax_r;
        REG_OUTPUT_CURRENT_REPORT: RDATA_OUT <= output_current_report_r;
        REG_LINK: RDATA_OUT <= link_edges_r;
        REG_TEMP: RDATA_OUT <= {8'h00, temp_r};
        REG_ZEROCFG: RDATA_OUT <= {15'h0000, zero_good_r};
        default: RDATA_OUT <= '0;
      endcase
    end
  end

  assign TARGET_OUT = target_r;
  assign BUS_DATA_OUT = 1'b0;
  assign BUS_DATA_OE_OUT = 1'b0;
  assign BUS_ALERT_N_OUT = 1'b0;
  assign BUS_ALERT_OE_OUT = alert_r;
  assign OVER_TEMP_FLAG_N_OUT = ~hot_r;

  // ****************************************
  // checks
  // ****************************************
  default clocking cb @(posedge CLOCK_IN); endclocking
  default disable iff (!RST_N_IN);

  chk_fast_trip: assert property (active && enable_s && supply_ok_s && fast_lim_s
    |=> state_r == ST_OC) else $error("fast limit did not trip");
  chk_oc_timer: assert property (oc_expire && active && enable_s && supply_ok_s
    |=> state_r == ST_OC) else $error("latch-off timer did not trip");
  chk_oc_restart: assert property (!cur_lim_s |=> oc_cnt_r == '0)
    else $error("latch-off timer not restarted");
  chk_supply_stop: assert property (active && !supply_ok_s
    |=> state_r == ST_OFF ##1 !HIGH_SIDE_GATE_OUT && !LOW_SIDE_GATE_OUT)
    else $error("gates driven after supply loss");
  chk_ov_trip: assert property (state_r == ST_RUN && enable_s && supply_ok_s && ov_s
    && !fast_lim_s && !oc_expire |=> ##1 !HIGH_SIDE_GATE_OUT && LOW_SIDE_GATE_OUT)
    else $error("overvoltage gates wrong");
  chk_soft_fixed: assert property (state_r == ST_SOFT && enable_s && supply_ok_s
    && ov_fixed_s && !fast_lim_s && !oc_expire |=> state_r == ST_OV_RAMP)
    else $error("soft start fixed limit ignored");
  chk_ramp_down: assert property (state_r == ST_OV_RAMP && step && target_r != 8'h00
    |=> target_r == $past(target_r) - 8'h01) else $error("target not ramping down");
  chk_ov_hold: assert property (state_r == ST_OV_HOLD [*2]
    |-> !HIGH_SIDE_GATE_OUT && LOW_SIDE_GATE_OUT) else $error("hold gates wrong");
  chk_boot_stable: assert property (cfg_done |=> $stable(bus_addr_r) && $stable(boot_hi_r))
    else $error("boot config changed");
  chk_good_uv: assert property (state_r == ST_RUN && uv_s && target_r != 8'h00
    |=> !OUTPUT_GOOD_OUT) else $error("output good high in undervoltage");

  cov_run: cover property (state_r == ST_SOFT ##1 state_r == ST_RUN);
  cov_oc: cover property (state_r == ST_RUN ##1 state_r == ST_OC);
  cov_ov_hold: cover property (state_r == ST_OV_RAMP ##1 state_r == ST_OV_HOLD);

endmodule : regulator_supervisor
`default_nettype wire

// ===== sim/host_link_model.sv
// Purpose: host side of the three-wire link and the enable pin
// Assumes: link clock idles low, data line pulled up outside frames
// Notes: frames are paced by delays, unrelated to the core clock
`timescale 1ns/10ps
`default_nettype none
module host_link_model (
  input wire logic clk_in,
  output logic bus_clk_out,
  output logic bus_data_out,
  output logic enable_out
);
  initial begin
    bus_clk_out = 1'b0;
    bus_data_out = 1'b1;
    enable_out = 1'b1;
  end
  task automatic frame(input int n);
    #7;
    for (int i = 0; i < n; i++) begin
      bus_data_out = i[0];
      #160 bus_clk_out = 1'b1;
      #160 bus_clk_out = 1'b0;
    end
    bus_data_out = 1'b1;
  endtask : frame
  task automatic cycle_enable;
    @(posedge clk_in);
    enable_out <= 1'b0;
    repeat (4) @(posedge clk_in);
    enable_out <= 1'b1;
  endtask : cycle_enable
endmodule : host_link_model
`default_nettype wire

// ===== sim/testbench.sv
// Purpose: self-checking bench of the regulator supervisor
// Assumes: short step dividers, converter readings in mV
// Notes: state is observed through the status register
`timescale 1ns/10ps
`default_nettype none
module testbench;
  import supervisor_pkg::*;
  logic clk = 0, rst_n = 0, wr = 0, rd = 0, av = 0, vcc = 1, vin = 1, cl = 0, fcl = 0;
  logic uv = 0, ov = 0, fov = 0, pwm = 0;
  logic [7:0] addr = '0;
  logic [15:0] wdata = '0, q, v;
  logic [10:0] code = '0;
  logic [1:0] chan = '0;
  logic [15:0] rdata;
  logic [7:0] tgt;
  logic bclk, bdat, en, an, aoe, hs, ls, og, otn;
  int fail_count = 0, compares = 0;
  host_link_model host (.clk_in(clk), .bus_clk_out(bclk), .bus_data_out(bdat), .enable_out(en));
  regulator_supervisor #(.STEP_DIV_FAST(2), .STEP_DIV_MID(3), .STEP_DIV_SLOW(4)) dut (
    .CLOCK_IN(clk), .RST_N_IN(rst_n), .ADDR_IN(addr), .WDATA_IN(wdata), .WR_IN(wr),
    .RD_IN(rd), .RDATA_OUT(rdata), .ADC_CODE_IN(code), .ADC_CHAN_IN(chan),
    .ADC_VALID_IN(av), .ENABLE_IN(en), .VCC_OK_IN(vcc), .VIN_OK_IN(vin),
    .CURRENT_LIMIT_SENSE_IN(cl), .FAST_CURRENT_LIMIT_IN(fcl),
    .UNDERVOLTAGE_COMPARATOR_IN(uv), .OUT_ABOVE_OV_IN(ov), .OUT_ABOVE_FIXED_OV_IN(fov),
    .PWM_IN(pwm), .BUS_CLK_IN(bclk), .BUS_DATA_IN(bdat), .BUS_DATA_OUT(),
    .BUS_DATA_OE_OUT(), .BUS_ALERT_N_OUT(an), .BUS_ALERT_OE_OUT(aoe), .TARGET_OUT(tgt),
    .HIGH_SIDE_GATE_OUT(hs), .LOW_SIDE_GATE_OUT(ls), .OUTPUT_GOOD_OUT(og),
    .OVER_TEMP_FLAG_N_OUT(otn));
  initial begin
    forever #20 clk = ~clk;
  end
  // ****************************************
  // access tasks
  // ****************************************
  task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
    compares++;
    if (seen !== exp) begin
      fail_count++;
      $display("unexpected %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk
  task automatic wr_reg(input logic [7:0] a, input logic [15:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask : wr_reg
  task automatic rd_reg(input logic [7:0] a, output logic [15:0] d);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 d = rdata;
  endtask : rd_reg
  task automatic adc(input logic [1:0] c, input logic [10:0] mv);
    @(posedge clk);
    chan <= c;
    code <= mv;
    av <= 1'b1;
    @(posedge clk);
    av <= 1'b0;
  endtask : adc
  task automatic wait_st(input logic [2:0] s, input int n);
    rd_reg(REG_STATUS, q);
    for (int i = 0; i < n && q[2:0] !== s; i++) rd_reg(REG_STATUS, q);
    chk("state", {13'h0, q[2:0]}, {13'h0, s});
  endtask : wait_st
  task automatic wait_tgt(input logic [7:0] t);
    for (int i = 0; i < 12000 && tgt !== t; i++) @(posedge clk);
    chk("target", {8'h0, tgt}, {8'h0, t});
  endtask : wait_tgt
  task automatic bring_up;
    adc(CH_BOOT, 11'h384);
    adc(CH_MAX_CURRENT_PROGRAM_PIN, 11'h3e8);
    wait_st(3'b010, 400);
  endtask : bring_up
  task automatic conclude;
    $display("comparisons %0d mismatches %0d", compares, fail_count);
    if (fail_count == 0 && compares > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : conclude
  initial begin
    #4000000;
    fail_count++;
    $display("watchdog expired");
    conclude();
  end
  // ****************************************
  // tests
  // ****************************************
  initial begin
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    repeat (5) @(posedge clk);
    bring_up();
    rd_reg(REG_BOOTCFG, q);
    chk("boot config", q, 16'h0010);
    rd_reg(REG_ICCMAX, q);
    chk("max current", q, 16'h7d00);
    chk("boot target", {8'h0, tgt}, {8'h0, BOOT_CODE_HI});
    adc(CH_BOOT, 11'h000);
    wr_reg(REG_BOOTCFG, 16'h0003);
    rd_reg(REG_BOOTCFG, q);
    chk("boot kept", q, 16'h0010);
    wr_reg(REG_RATE, 16'h0003);
    rd_reg(REG_RATE, q);
    chk("rate", q, 16'h0002);
    rd_reg(8'h55, q);
    chk("unmapped", q, 16'h0000);
    rd_reg(REG_LINK, v);
    host.frame(6);
    repeat (4) @(posedge clk);
    rd_reg(REG_LINK, q);
    chk("link edges", q, v + 16'h0006);
    $display("configuration test done");
    adc(CH_TEMP, 11'h118);
    adc(CH_OUTPUT_CURRENT_REPORT, 11'h3e8);
    rd_reg(REG_TEMP, q);
    chk("temperature", q, 16'h0073);
    chk("hot flag", {15'h0, otn}, 16'h0000);
    chk("alert", {14'h0, an, aoe}, 16'h0001);
    rd_reg(REG_OUTPUT_CURRENT_REPORT, q);
    chk("output current", q, 16'h3e80);
    adc(CH_TEMP, 11'h1f4);
    repeat (2) @(posedge clk);
    chk("hot cleared", {14'h0, otn, aoe}, 16'h0002);
    @(posedge clk) uv <= 1'b1;
    repeat (5) @(posedge clk);
    chk("good low", {15'h0, og}, 16'h0000);
    @(posedge clk) uv <= 1'b0;
    repeat (5) @(posedge clk);
    chk("good high", {15'h0, og}, 16'h0001);
    wr_reg(REG_ZEROCFG, 16'h0001);
    wr_reg(REG_VID, 16'h0000);
    wait_tgt(8'h00);
    repeat (3) @(posedge clk);
    chk("zero good set", {15'h0, og}, 16'h0001);
    wr_reg(REG_ZEROCFG, 16'h0000);
    repeat (3) @(posedge clk);
    chk("zero good clear", {15'h0, og}, 16'h0000);
    wr_reg(REG_VID, {8'h0, BOOT_CODE_HI});
    wait_tgt(BOOT_CODE_HI);
    $display("telemetry test done");
    @(posedge clk) cl <= 1'b1;
    repeat (1200) @(posedge clk);
    cl <= 1'b0;
    repeat (5) @(posedge clk);
    wait_st(3'b010, 0);
    @(posedge clk) cl <= 1'b1;
    repeat (1260) @(posedge clk);
    wait_st(3'b100, 0);
    cl <= 1'b0;
    host.cycle_enable();
    bring_up();
    @(posedge clk) fcl <= 1'b1;
    wait_st(3'b100, 3);
    chk("fast gates", {14'h0, hs, ls}, 16'h0000);
    fcl <= 1'b0;
    host.cycle_enable();
    bring_up();
    @(posedge clk) vin <= 1'b0;
    wait_st(3'b000, 5);
    chk("lockout gates", {14'h0, hs, ls}, 16'h0000);
    vin <= 1'b1;
    wait_st(3'b010, 400);
    $display("current and supply test done");
    @(posedge clk) ov <= 1'b1;
    wait_st(3'b110, 5);
    chk("ov gates", {14'h0, hs, ls}, 16'h0001);
    ov <= 1'b0;
    repeat (5) @(posedge clk);
    chk("ramp gates", {14'h0, hs, ls}, 16'h0000);
    repeat (20) @(posedge clk);
    chk("slow ramp", {15'h0, tgt < BOOT_CODE_HI && tgt > 8'h60}, 16'h0001);
    wait_tgt(8'h00);
    wait_st(3'b111, 5);
    chk("hold gates", {14'h0, hs, ls}, 16'h0001);
    host.cycle_enable();
    bring_up();
    @(posedge clk) vin <= 1'b0;
    wait_st(3'b000, 5);
    vin <= 1'b1;
    wait_st(3'b011, 50);
    ov <= 1'b1;
    repeat (5) @(posedge clk);
    wait_st(3'b011, 0);
    ov <= 1'b0;
    fov <= 1'b1;
    wait_st(3'b110, 5);
    fov <= 1'b0;
    $display("overvoltage test done");
    @(posedge clk) rst_n <= 1'b0;
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    rd_reg(REG_STATUS, q);
    chk("reset status", q, 16'h0000);
    adc(CH_BOOT, 11'h30d);
    adc(CH_MAX_CURRENT_PROGRAM_PIN, 11'h0c8);
    rd_reg(REG_BOOTCFG, q);
    chk("low boot config", q, 16'h0008);
    rd_reg(REG_ICCMAX, q);
    chk("low max current", q, 16'h1900);
    wait_st(3'b010, 400);
    chk("low boot target", {8'h0, tgt}, {8'h0, BOOT_CODE_LO});
    wr_reg(REG_RATE, 16'h0001);
    rd_reg(REG_RATE, q);
    chk("mid rate", q, 16'h0001);
    $display("reset test done");
    conclude();
  end
endmodule : testbench
`default_nettype wire
